// ### rtl/bas_map.vh
// constants for the bipolar converter serial port
`ifndef BAS_MAP_VH
`define BAS_MAP_VH
`define BAS_FRAME_BITS 5'd16
`define BAS_MAG_BITS 12
`define BAS_ID_MSB 15
`define BAS_SIGN_BIT 12
`define BAS_CTRL_ADDR 4'h0
`define BAS_SEQ_ADDR 4'h1
`define BAS_REFCFG_ADDR 4'h2
`define BAS_STATUS_ADDR 4'h3
`define BAS_CTRL_WR_BIT 15
`define BAS_CTRL_CH_LSB 10
`define BAS_CTRL_MODE_LSB 8
`define BAS_CTRL_SEQ_BIT 3
`define BAS_CTRL_REF_BIT 2
`define BAS_REF_EN_BIT 0
`define BAS_CTRL_RESET 16'h0000
`define BAS_SEQ_RESET 8'h01
`define BAS_REF_RESET 1'b0
`define BAS_FIFO_DEPTH 8
`define BAS_FIFO_AW 3
`endif

// ### rtl/bas_fifo.v
// small valid/ready fifo holding finished conversion words
`timescale 1ns/1ps
`default_nettype none
module bas_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire sys_clk_i,
  input wire rstn_i,
  input wire in_valid_i,
  output wire in_ready_o,
  input wire [WIDTH-1:0] in_data_i,
  output wire out_valid_o,
  input wire out_ready_i,
  output wire [WIDTH-1:0] out_data_o,
  output wire [AW:0] level_o
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0] wr_reg;
  reg [AW:0] rd_reg;
  wire [AW:0] used;
  wire do_wr;
  wire do_rd;
  assign used = wr_reg - rd_reg;
  assign in_ready_o = (used != DEPTH[AW:0]);
  assign out_valid_o = (used != {(AW+1){1'b0}});
  assign out_data_o = mem[rd_reg[AW-1:0]];
  assign level_o = used;
  assign do_wr = in_valid_i & in_ready_o;
  assign do_rd = out_valid_o & out_ready_i;
  always @(posedge sys_clk_i) begin
    if (do_wr) begin
      mem[wr_reg[AW-1:0]] <= in_data_i;
    end
  end
  always @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      wr_reg <= {(AW+1){1'b0}};
      rd_reg <= {(AW+1){1'b0}};
    end else begin
      if (do_wr) begin
        wr_reg <= wr_reg + {{AW{1'b0}}, 1'b1};
      end
      if (do_rd) begin
        rd_reg <= rd_reg + {{AW{1'b0}}, 1'b1};
      end
    end
  end
endmodule
`default_nettype wire

// ### rtl/bas_serial_port.v
// serial port and conversion control of the bipolar converter
//
// Functional notes
// R1: host serial clock times access and conversion
// R2: output bit changes on serial clock fall
// R3: host gives sixteen clocks per frame
// R4: frame is channel id, sign, magnitude
// R5: shift out msb first, id top bit
// R6: frame select low starts conversion, opens window
// R7: input bit captured on serial clock fall
// R8: mux output follows control or sequence channel
// R9: internal reference disabled after power-up
// R10: channel and mode bits from control register
// R11: power-up selects channel zero on mux
// R12: output released while frame select high
//
// Chosen here: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`include "bas_map.vh"
`default_nettype none
module bas_serial_port (
  input wire sys_clk_i,
  input wire rstn_i,
  input wire frame_n_i,
  input wire sclk_i,
  input wire din_i,
  output reg dout_o,
  output reg dout_oe_o,
  input wire [12:0] sample_i,
  output wire [2:0] positive_mux_output_o,
  output wire [1:0] input_mode_o,
  output wire internal_ref_en_o,
  output wire conv_busy_o,
  output wire word_valid_o,
  input wire word_ready_i,
  output wire [15:0] word_data_o,
  input wire [3:0] addr_i,
  input wire [15:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [15:0] rdata_o
);
  reg [1:0] frame_sync_reg;
  reg [1:0] sclk_sync_reg;
  reg [1:0] din_sync_reg;
  reg sclk_last_reg;
  reg active_reg;
  reg frame_last_reg;
  reg [4:0] bit_cnt_reg;
  reg [15:0] out_sh_reg;
  reg [15:0] in_sh_reg;
  reg [15:0] ctrl_reg;
  reg [7:0] seq_reg;
  reg [2:0] seq_ch_reg;
  reg ref_en_reg;
  reg [2:0] conv_ch_reg;
  reg conv_busy_reg;
  reg ovf_reg;
  wire frame_q;
  wire sclk_q;
  wire din_q;
  wire frame_fall;
  wire frame_rise;
  wire sclk_fall;
  wire [2:0] sel_ch;
  wire fifo_in_ready;
  wire fifo_in_valid;
  wire [3:0] fifo_level;
  wire software_ctrl_wr;

  function [2:0] next_seq_ch;
    input [2:0] cur;
    input [7:0] mask;
    integer k;
    reg [2:0] cand;
    reg found;
    begin
      next_seq_ch = cur;
      found = 1'b0;
      for (k = 1; k <= 8; k = k + 1) begin
        cand = cur + k[2:0];
        if (!found && mask[cand]) begin
          next_seq_ch = cand;
          found = 1'b1;
        end
      end
    end
  endfunction

  assign frame_q = frame_sync_reg[1];
  assign sclk_q = sclk_sync_reg[1];
  assign din_q = din_sync_reg[1];
  // pins cross two flops; sclk edges found on the synced copy
  assign sclk_fall = sclk_last_reg & ~sclk_q & active_reg; // [R1]
  assign frame_fall = frame_last_reg & ~frame_q;
  assign frame_rise = ~frame_last_reg & frame_q;

  // sequencer picks next enabled channel, else control channel
  assign sel_ch = ctrl_reg[`BAS_CTRL_SEQ_BIT] ? seq_ch_reg
                  : ctrl_reg[`BAS_CTRL_CH_LSB +: 3]; // [R8] [R10]
  assign positive_mux_output_o = sel_ch; // [R8] [R11]
  assign input_mode_o = ctrl_reg[`BAS_CTRL_MODE_LSB +: 2]; // [R10]
  assign internal_ref_en_o = ref_en_reg; // [R9]
  assign conv_busy_o = conv_busy_reg;
  // software may not retarget the mux mid-frame
  assign software_ctrl_wr = wr_i && (addr_i == `BAS_CTRL_ADDR) && !active_reg;

  always @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      frame_sync_reg <= 2'b11;
      sclk_sync_reg <= 2'b00;
      din_sync_reg <= 2'b00;
      sclk_last_reg <= 1'b0;
      frame_last_reg <= 1'b1;
    end else begin
      frame_sync_reg <= {frame_sync_reg[0], frame_n_i};
      sclk_sync_reg <= {sclk_sync_reg[0], sclk_i};
      din_sync_reg <= {din_sync_reg[0], din_i};
      sclk_last_reg <= sclk_q;
      frame_last_reg <= frame_q;
    end
  end

  // frame engine: conversion starts at frame select fall
  always @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      active_reg <= 1'b0;
      bit_cnt_reg <= 5'd0;
      out_sh_reg <= 16'h0000;
      in_sh_reg <= 16'h0000;
      dout_o <= 1'b0;
      dout_oe_o <= 1'b0;
      conv_ch_reg <= 3'h0;
      conv_busy_reg <= 1'b0;
      ctrl_reg <= `BAS_CTRL_RESET; // [R11]
      seq_ch_reg <= 3'h0;
      ref_en_reg <= `BAS_REF_RESET; // [R9]
    end else begin
      if (frame_fall) begin
        active_reg <= 1'b1; // [R6]
        conv_busy_reg <= 1'b1; // [R6]
        bit_cnt_reg <= 5'd0;
        conv_ch_reg <= sel_ch;
        // result of previous conversion goes out this frame
        out_sh_reg <= {conv_ch_reg, sample_i}; // [R4]
        dout_o <= conv_ch_reg[2]; // [R5]
        dout_oe_o <= 1'b1;
      end else if (frame_rise) begin
        active_reg <= 1'b0;
        conv_busy_reg <= 1'b0;
        dout_oe_o <= 1'b0; // [R12]
        // short frames abort; only a full word updates registers
        if (bit_cnt_reg == `BAS_FRAME_BITS) begin // [R3]
          if (in_sh_reg[`BAS_CTRL_WR_BIT]) begin
            if (in_sh_reg[14:11] == `BAS_CTRL_ADDR) begin
              ctrl_reg <= {5'h00, in_sh_reg[10:0]};
              seq_ch_reg <= 3'h0;
            end else if (in_sh_reg[14:11] == `BAS_REFCFG_ADDR) begin
              ref_en_reg <= in_sh_reg[`BAS_REF_EN_BIT]; // [R9]
            end
          end
          if (ctrl_reg[`BAS_CTRL_SEQ_BIT]) begin
            seq_ch_reg <= next_seq_ch(seq_ch_reg, seq_reg);
          end
        end
      end else if (sclk_fall && bit_cnt_reg != `BAS_FRAME_BITS) begin
        in_sh_reg <= {in_sh_reg[14:0], din_q}; // [R7]
        out_sh_reg <= {out_sh_reg[14:0], 1'b0}; // [R5]
        dout_o <= out_sh_reg[14]; // [R2]
        bit_cnt_reg <= bit_cnt_reg + 5'd1;
        if (bit_cnt_reg == `BAS_FRAME_BITS - 5'd1) begin
          conv_busy_reg <= 1'b0; // [R1]
        end
      end
      if (software_ctrl_wr) begin
        ctrl_reg <= wdata_i;
      end
      if (wr_i && addr_i == `BAS_REFCFG_ADDR) begin
        ref_en_reg <= wdata_i[`BAS_REF_EN_BIT];
      end
    end
  end

  always @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      seq_reg <= `BAS_SEQ_RESET;
    end else if (wr_i && addr_i == `BAS_SEQ_ADDR) begin
      seq_reg <= wdata_i[7:0];
    end
  end

  // finished word pushed into fifo at sixteenth clock
  assign fifo_in_valid = sclk_fall && (bit_cnt_reg == `BAS_FRAME_BITS - 5'd1)
                         && !frame_fall && !frame_rise;

  always @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      ovf_reg <= 1'b0;
    end else if (fifo_in_valid && !fifo_in_ready) begin
      ovf_reg <= 1'b1;
    end else if (rd_i && addr_i == `BAS_STATUS_ADDR) begin
      ovf_reg <= 1'b0;
    end
  end

  bas_fifo #(
    .WIDTH(16),
    .DEPTH(`BAS_FIFO_DEPTH),
    .AW(`BAS_FIFO_AW)
  ) u_fifo (
    .sys_clk_i(sys_clk_i),
    .rstn_i(rstn_i),
    .in_valid_i(fifo_in_valid),
    .in_ready_o(fifo_in_ready),
    .in_data_i({conv_ch_reg, sample_i}),
    .out_valid_o(word_valid_o),
    .out_ready_i(word_ready_i),
    .out_data_o(word_data_o),
    .level_o(fifo_level)
  );

  always @(posedge sys_clk_i) begin
    if (!rstn_i) begin
      rdata_o <= 16'h0000;
    end else if (rd_i) begin
      case (addr_i)
        `BAS_CTRL_ADDR: rdata_o <= ctrl_reg;
        `BAS_SEQ_ADDR: rdata_o <= {8'h00, seq_reg};
        `BAS_REFCFG_ADDR: rdata_o <= {15'h0000, ref_en_reg};
        `BAS_STATUS_ADDR: rdata_o <= {7'h00, ovf_reg, fifo_level,
                                      conv_busy_reg, sel_ch};
        default: rdata_o <= 16'h0000;
      endcase
    end else begin
      rdata_o <= 16'h0000;
    end
  end
endmodule
`default_nettype wire

// ### verif/bas_serial_port_props.sv
// checker for the converter serial port
`timescale 1ns/1ps
`default_nettype none
module bas_serial_port_props (
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic frame_n_i,
  input wire logic sclk_i,
  input wire logic dout_o,
  input wire logic dout_oe_o,
  input wire logic [2:0] positive_mux_output_o,
  input wire logic internal_ref_en_o,
  input wire logic conv_busy_o,
  input wire logic rd_i,
  input wire logic [15:0] rdata_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);
  property p_ref; $rose(rstn_i) |-> !internal_ref_en_o; endproperty
  a_ref: assert property (p_ref) else $error("ref on at reset");
  property p_mux; $rose(rstn_i) |-> positive_mux_output_o == 3'h0; endproperty
  a_mux: assert property (p_mux) else $error("mux not zero");
  property p_quiet; $rose(rstn_i) |-> !dout_oe_o && !dout_o; endproperty
  a_quiet: assert property (p_quiet) else $error("driving at reset");
  property p_rel; frame_n_i [*8] |-> !dout_oe_o; endproperty
  a_rel: assert property (p_rel) else $error("not released");
  property p_start; $rose(dout_oe_o) |-> !$past(frame_n_i) && !$past(frame_n_i, 2); endproperty
  a_start: assert property (p_start) else $error("drive without select");
  property p_busy; $rose(dout_oe_o) |-> ##[0:2] conv_busy_o; endproperty
  a_busy: assert property (p_busy) else $error("no conversion");
  // sclk low lasts four cycles, so a fall is always in view
  property p_fall;
    dout_oe_o && $past(dout_oe_o) && $changed(dout_o)
      |-> !$past(sclk_i) || !$past(sclk_i, 2) || !$past(sclk_i, 3) || !$past(sclk_i, 4);
  endproperty
  a_fall: assert property (p_fall) else $error("shift off fall");
  property p_rdz; !$past(rd_i) |-> rdata_o == 16'h0000; endproperty
  a_rdz: assert property (p_rdz) else $error("read data stale");
endmodule
bind bas_serial_port bas_serial_port_props u_props (.sys_clk_i, .rstn_i, .frame_n_i,
  .sclk_i, .dout_o, .dout_oe_o, .positive_mux_output_o, .internal_ref_en_o, .conv_busy_o,
  .rd_i, .rdata_o);
`default_nettype wire

// ### verif/bas_host_model.sv
// host serial port model
`timescale 1ns/1ps
`default_nettype none
module bas_host_model (
  output logic frame_n_o,
  output logic sclk_o,
  output logic din_o,
  input wire logic dout_i,
  input wire logic dout_oe_i
);
  initial begin
    frame_n_o = 1'b1;
    sclk_o = 1'b1; // still between frames
    din_o = 1'b0;
  end
  task automatic frame(input logic [15:0] w, output logic [15:0] r);
    integer i;
    #7; // off the system clock phase
    frame_n_o = 1'b0;
    din_o = w[15];
    #320;
    for (i = 15; i >= 0; i--) begin
      r[i] = dout_oe_i ? dout_i : 1'bx;
      sclk_o = 1'b0;
      #160;
      sclk_o = 1'b1;
      if (i > 0) din_o = w[i-1];
      #160;
    end
    frame_n_o = 1'b1;
    #640;
  endtask
endmodule
`default_nettype wire

// ### verif/bas_serial_port_test.sv
// bench for the converter serial port
`timescale 1ns/1ps
`default_nettype none
module bas_serial_port_test;
  logic sys_clk_i, rstn_i, wr_i, rd_i, word_ready_i;
  logic [3:0] addr_i;
  logic [15:0] wdata_i, r, q[$];
  logic [12:0] sample_i;
  logic [2:0] ch;
  logic [31:0] seed = 32'h0000_3cf8; // 15608
  wire frame_n_i, sclk_i, din_i, dout_o, dout_oe_o, internal_ref_en_o, conv_busy_o;
  wire word_valid_o;
  wire [2:0] positive_mux_output_o;
  wire [1:0] input_mode_o;
  wire [15:0] word_data_o, rdata_o;
  int err_count = 0, total_checks = 0, i;
  initial begin
    sys_clk_i = 1'b0;
    forever #20 sys_clk_i = ~sys_clk_i;
  end
  bas_serial_port dut (.sys_clk_i, .rstn_i, .frame_n_i, .sclk_i, .din_i, .dout_o, .dout_oe_o,
    .sample_i, .positive_mux_output_o, .input_mode_o, .internal_ref_en_o, .conv_busy_o,
    .word_valid_o, .word_ready_i, .word_data_o, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o);
  bas_host_model host (.frame_n_o(frame_n_i), .sclk_o(sclk_i), .din_o(din_i),
    .dout_i(dout_o), .dout_oe_i(dout_oe_o));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge sys_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    #1 r = rdata_o;
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
  endtask
  // scoreboard: oldest note against each accepted word while notes remain
  always @(posedge sys_clk_i) begin
    if (rstn_i && word_valid_o && word_ready_i && q.size() > 0) begin
      check(word_data_o, q.pop_front());
    end
  end
  initial begin
    {rstn_i, wr_i, rd_i, addr_i, wdata_i, sample_i} = '0;
    word_ready_i = 1'b1;
    repeat (4) @(posedge sys_clk_i);
    rstn_i <= 1'b1;
    @(posedge sys_clk_i);
    #1 check({13'h0, positive_mux_output_o}, 16'h0000);
    rd(4'h2);
    check(r, 16'h0000);
    rd(4'hf);
    check(r, 16'h0000);
    for (i = 0; i < 4; i++) begin
      seed = xs(seed);
      ch = seed[2:0];
      @(posedge sys_clk_i);
      sample_i <= seed[20:8];
      wr(4'h0, {3'h0, ch, seed[22:21], 8'h00});
      #1 check({13'h0, positive_mux_output_o}, {13'h0, ch});
      check({14'h0, input_mode_o}, {14'h0, seed[22:21]});
      // first frame only primes: it reports the previous result
      host.frame(16'h0000, r);
      host.frame(i == 0 ? 16'h9001 : 16'h0000, r);
      check(r, {ch, sample_i});
    end
    check({15'h0, internal_ref_en_o}, 16'h0001);
    @(posedge sys_clk_i);
    word_ready_i <= 1'b0;
    for (i = 0; i < 9; i++) begin
      host.frame(16'h0000, r);
      if (i < 8) q.push_back({ch, sample_i});
    end
    rd(4'h3);
    check({11'h0, r[8:4]}, 16'h0018);
    for (i = 0; i < 400 && q.size() > 0; i++) begin
      @(posedge sys_clk_i);
      seed = xs(seed);
      word_ready_i <= seed[0];
    end
    check(16'(q.size()), 16'h0000);
    // sequencer over channels 2 and 5, one step per full frame
    wr(4'h1, 16'h0024);
    wr(4'h0, 16'h0008);
    #1 check({13'h0, positive_mux_output_o}, 16'h0000);
    host.frame(16'h0000, r);
    check({13'h0, positive_mux_output_o}, 16'h0002);
    host.frame(16'h0000, r);
    check({13'h0, positive_mux_output_o}, 16'h0005);
    host.frame(16'h0000, r);
    check({13'h0, positive_mux_output_o}, 16'h0002);
    summarize();
  end
endmodule
`default_nettype wire
